// [inc/asrp_regs.svh]
/*
 * Register offsets, field positions, reset values and timing counts for the
 * serial register port of the data-acquisition converter.
 * Assumes inclusion by bare name from the serial port design file.
 */
// Notes on behaviour
// [RQ1] Host lowers select before first active clock edge.
// [RQ2] Seven more active edges latch remaining instruction bits.
// [RQ3] Select high resets the serial interface state.
// [RQ4] Conversion starts on second converter-clock fall after write.
// [RQ5] Sixteen-bit write loads both registers at once.
// [RQ6] Second byte address is first address XOR one.
// [RQ7] Read data driven from next non-active edge.
// [RQ8] Read bits change only on non-active edges.
// [RQ9] Two-wire data pin released after last read edge.
// [RQ10] Output pin floats only while select is high.
// [RQ11] After read, next eight edges form instruction.
// [RQ12] Read byte reflects registers at its first edge.
// [RQ13] Mux setting from direct instruction or gain/mux register.
// [RQ14] Mux mode bit: zero differential, one single-ended.
// [RQ15] Differential pair from two bits, polarity bit swaps.
// [RQ16] Single-ended line n from three-bit code n.
// [RQ17] Registers eight bits wide, all cleared on reset.
// [RQ18] Result low byte: bits five..zero, zero, over-range.
// [RQ19] Result is two's complement by default.
// [RQ20] Shift order set by serial control bit-order bits.
// [RQ21] Over-range set on amplifier limit, details in register two.
// [RQ22] Instruction: mode, read, sixteen-bit, five-bit address.
// [RQ23] Eight-bit write to register zero resets everything.
// [RQ24] Write data committed only after final data edge.
`ifndef ASRP_REGS_SVH
`define ASRP_REGS_SVH

// ********************************************************************
// Register addresses.
// ********************************************************************
`define ASRP_ADDR_RES_LO   5'h00
`define ASRP_ADDR_RES_HI   5'h01
`define ASRP_ADDR_AMP_VLD  5'h02
`define ASRP_ADDR_ADC_CTL  5'h03
`define ASRP_ADDR_GAIN_MUX 5'h04
`define ASRP_ADDR_DIO_ST   5'h05
`define ASRP_ADDR_DIO_DIR  5'h06
`define ASRP_ADDR_REF_OSC  5'h07
`define ASRP_ADDR_SER_CTL  5'h18
`define ASRP_ADDR_ID       5'h1F

// ********************************************************************
// Field positions and constants.
// ********************************************************************
`define ASRP_INS_DIRECT    7
`define ASRP_INS_READ      6
`define ASRP_INS_WIDE      5
`define ASRP_CNV_BIT       7
`define ASRP_BIN_BIT       5
`define ASRP_SER_LSB_HI    7
`define ASRP_SER_LSB_LO    0
`define ASRP_SER_2W_HI     6
`define ASRP_SER_2W_LO     1
`define ASRP_BIN_FLIP      14'h2000
`define ASRP_LAST_BIT      4'h7
`define ASRP_CONVERTER_CLOCK_FALLS    1'h1
`define ASRP_REG_RST       8'h00

`endif

// [inc/asrp_pkg.sv]
/*
 * Types of the serial register port: serial state machine and the packed
 * state record that the port registers as a whole.
 * Assumes asrp_regs.svh is on the include path.
 */
package asrp_pkg;

	// ********************************************************************
	// Serial state machine; instruction -> write flips one bit, instruction -> read flips both.
	// ********************************************************************
	typedef enum logic [1:0] {
		ASRP_S_INSTR = 2'h0,
		ASRP_S_WDATA = 2'h1,
		ASRP_S_RDATA = 2'h3
	} asrp_fsm_e;

	// ********************************************************************
	// Whole state of the port.
	// ********************************************************************
	typedef struct packed {
		logic [1:0]  sel_p;    // Select synchroniser, [0] first stage.
		logic [1:0]  ck_p;     // Serial clock synchroniser.
		logic        ck_d;     // Serial clock history for edge finding.
		logic [1:0]  di_p;     // Serial data synchroniser.
		logic [1:0]  es_p;     // Edge-select synchroniser.
		logic [1:0]  dc_p;     // Converter clock synchroniser.
		logic        dc_d;
		asrp_fsm_e   fsm;
		logic [3:0]  bit_cnt;
		logic [7:0]  sh;       // Incoming bits, in arrival order.
		logic [7:0]  wfirst;   // First byte of a wide write, held back.
		logic [4:0]  addr;
		logic        wide;
		logic        second;
		logic [7:0]  rd_sh;    // Outgoing bits, next bit in [7].
		logic        dout;
		logic        din_en;
		logic        rel_pend;
		logic        arm;
		logic        dcnt;
		logic        busy;
		logic        start;
		logic [7:0]  r_adc;
		logic [6:0]  r_gmux;
		logic [3:0]  r_dio;
		logic [3:0]  r_dir;
		logic [7:0]  r_ref;
		logic [7:0]  r_ser;
		logic [7:0]  res_lo;
		logic [7:0]  res_hi;
		logic [5:0]  amp_vld;
	} asrp_state_s;

endpackage

// [design/asrp_mux_decode.sv]
/*
 * Input multiplexer decode: turns the four-bit mux setting into the
 * positive and negative analog line numbers.
 * Assumes a registered setting on its input.
 */
module asrp_mux_decode
	import asrp_pkg::*;
(
	// Setting.
	input  wire logic [3:0] mux_cfg_i,
	// Decoded lines.
	output logic      [2:0] pos_line_o,
	output logic      [2:0] neg_line_o,
	output logic            single_ended_o
);

	// ********************************************************************
	// Decode.
	// ********************************************************************
	// Differential pairs are lines 2k and 2k+1; the polarity bit picks which
	// of the two is positive, so the negative line is always its partner.
	always_comb begin
		single_ended_o = mux_cfg_i[3]; // RQ14
		if (mux_cfg_i[3]) begin
			pos_line_o = mux_cfg_i[2:0]; // RQ16
			neg_line_o = 3'h0;           // Ignored: measured against ground.
		end else begin
			pos_line_o = {mux_cfg_i[1:0], mux_cfg_i[2]};  // RQ15
			neg_line_o = {mux_cfg_i[1:0], ~mux_cfg_i[2]}; // RQ15
		end
	end

endmodule // asrp_mux_decode

// [design/asrp_serial_port.sv]
/*
 * Serial register port of the data-acquisition converter: instruction,
 * write and read framing, the register file, conversion start timing and
 * result capture.
 * Assumes serial pins and the converter clock arrive unsynchronised, and
 * that the conversion engine reports on ref_clk_i.
 */
`include "asrp_regs.svh"

module asrp_serial_port
	import asrp_pkg::*;
#(
	parameter logic [7:0] ID_VALUE = 8'h3C // Arbitrary identification value.
) (
	// Clock, reset, enable.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	// Serial pins.
	input  wire logic        cs_n_i,
	input  wire logic        sclk_i,
	input  wire logic        edge_rise_i,
	input  wire logic        din_i,
	output logic             din_o,
	output logic             din_oe_n_o,
	output logic             dout_o,
	output logic             dout_oe_n_o,
	// Conversion engine.
	input  wire logic        converter_clock_i,
	input  wire logic        conv_done_i,
	input  wire logic [13:0] conv_result_i,
	input  wire logic        over_range_i,
	input  wire logic [5:0]  amp_valid_i,
	output logic             conv_start_o,
	output logic             convert_busy_o,
	// Configuration.
	output logic [2:0]       gain_o,
	output logic [2:0]       pos_line_o,
	output logic [2:0]       neg_line_o,
	output logic             single_ended_o,
	output logic [1:0]       clk_div_o,
	output logic [3:0]       dio_state_o,
	output logic [3:0]       dio_dir_o,
	output logic [7:0]       ref_ctrl_o
);

	asrp_state_s st_reg;
	asrp_state_s st_next;
	logic        sel;
	logic        act;
	logic        nact;
	logic        dfall;
	logic        lsb_first;
	logic        two_wire;
	logic [7:0]  shin;
	logic [7:0]  byte_in;
	logic [7:0]  rfr;
	logic        rst_cmd;
	logic        wr_en;
	logic        wr_wide;
	logic [4:0]  wr_addr;
	logic [7:0]  wr_data;

	// ********************************************************************
	// Helpers.
	// ********************************************************************
	// Bit order reversal for the least-significant-first mode.
	function automatic logic [7:0] ord(input logic [7:0] v, input logic lsb);
		logic [7:0] r;
		r = v;
		if (lsb) begin
			for (int i = 0; i < 8; i++) begin
				r[i] = v[7 - i];
			end
		end
		return r;
	endfunction

	// Register read view; the busy flag shows in the convert bit position.
	function automatic logic [7:0] rd(input asrp_state_s s, input logic [4:0] a);
		logic [7:0] v;
		v = `ASRP_REG_RST;
		case (a)
			`ASRP_ADDR_RES_LO:   v = s.res_lo;
			`ASRP_ADDR_RES_HI:   v = s.res_hi;
			`ASRP_ADDR_AMP_VLD:  v = {2'h0, s.amp_vld}; // RQ21
			`ASRP_ADDR_ADC_CTL:  v = s.r_adc;
			`ASRP_ADDR_GAIN_MUX: v = {s.busy, s.r_gmux};
			`ASRP_ADDR_DIO_ST:   v = {s.busy, 3'h0, s.r_dio};
			`ASRP_ADDR_DIO_DIR:  v = {4'h0, s.r_dir};
			`ASRP_ADDR_REF_OSC:  v = s.r_ref;
			`ASRP_ADDR_SER_CTL:  v = s.r_ser;
			`ASRP_ADDR_ID:       v = ID_VALUE;
			default:             v = `ASRP_REG_RST;
		endcase
		return v;
	endfunction

	// Register write; a convert bit in gain/mux or digital I/O arms a start.
	function automatic asrp_state_s put(input asrp_state_s s, input logic [4:0] a,
			input logic [7:0] d);
		asrp_state_s r;
		r = s;
		case (a)
			`ASRP_ADDR_ADC_CTL:  r.r_adc = d;
			`ASRP_ADDR_GAIN_MUX: r.r_gmux = d[6:0];
			`ASRP_ADDR_DIO_ST:   r.r_dio = d[3:0];
			`ASRP_ADDR_DIO_DIR:  r.r_dir = d[3:0];
			`ASRP_ADDR_REF_OSC:  r.r_ref = d;
			`ASRP_ADDR_SER_CTL:  r.r_ser = d;
			default:             r.r_adc = s.r_adc; // Read-only or unmapped.
		endcase
		if (d[`ASRP_CNV_BIT] && (a == `ASRP_ADDR_GAIN_MUX || a == `ASRP_ADDR_DIO_ST)) begin
			r.arm = 1'b1;
			r.dcnt = 1'b0;
		end
		return r;
	endfunction

	// ********************************************************************
	// Edge finding on synchronised pins.
	// ********************************************************************
	// Only the second synchroniser stages are looked at here.
	assign sel       = st_reg.sel_p[1];
	assign act       = st_reg.es_p[1] ? (st_reg.ck_p[1] & ~st_reg.ck_d)
	                                  : (~st_reg.ck_p[1] & st_reg.ck_d);
	assign nact      = (st_reg.ck_p[1] != st_reg.ck_d) & ~act;
	assign dfall     = ~st_reg.dc_p[1] & st_reg.dc_d;
	assign lsb_first = st_reg.r_ser[`ASRP_SER_LSB_HI] | st_reg.r_ser[`ASRP_SER_LSB_LO]; // RQ20
	assign two_wire  = st_reg.r_ser[`ASRP_SER_2W_HI] | st_reg.r_ser[`ASRP_SER_2W_LO];
	assign shin      = {st_reg.sh[6:0], st_reg.di_p[1]};
	assign byte_in   = ord(shin, lsb_first);
	// Refresh value of the byte under way, taken at its first active edge.
	assign rfr       = ord(rd(st_reg, st_reg.addr ^ {4'h0, st_reg.second}), lsb_first);

	// ********************************************************************
	// Next-state logic.
	// ********************************************************************
	// The whole port advances in one process so that a wide write, a reset
	// command and a conversion start all see one consistent snapshot.
	always_comb begin
		st_next = st_reg;
		rst_cmd = 1'b0;
		wr_en = 1'b0;
		wr_wide = 1'b0;
		wr_addr = st_reg.addr;
		wr_data = byte_in;
		st_next.sel_p = {st_reg.sel_p[0], ~cs_n_i};
		st_next.ck_p = {st_reg.ck_p[0], sclk_i};
		st_next.ck_d = st_reg.ck_p[1];
		st_next.di_p = {st_reg.di_p[0], din_i};
		st_next.es_p = {st_reg.es_p[0], edge_rise_i};
		st_next.dc_p = {st_reg.dc_p[0], converter_clock_i};
		st_next.dc_d = st_reg.dc_p[1];
		st_next.start = 1'b0;
		// Conversion start timing against converter clock falls.
		if (st_reg.arm && dfall) begin
			if (st_reg.dcnt == `ASRP_CONVERTER_CLOCK_FALLS) begin
				st_next.start = 1'b1; // RQ4
				st_next.busy = 1'b1;
				st_next.arm = 1'b0;
			end else begin
				st_next.dcnt = `ASRP_CONVERTER_CLOCK_FALLS;
			end
		end
		// Result capture; binary format flips the sign bit of the result.
		if (conv_done_i) begin
			st_next.busy = st_next.start; // A start in the same cycle wins.
			{st_next.res_hi, st_next.res_lo[7:2]} = conv_result_i
				^ (st_reg.r_adc[`ASRP_BIN_BIT] ? `ASRP_BIN_FLIP : 14'h0000); // RQ19
			st_next.res_lo[1] = 1'b0;                                        // RQ18
			st_next.res_lo[0] = over_range_i | (|amp_valid_i);               // RQ21
			st_next.amp_vld = amp_valid_i;
		end
		if (!sel) begin
			// Deselected: serial interface returns to its idle state.
			st_next.fsm = ASRP_S_INSTR; // RQ3
			st_next.bit_cnt = 4'h0;
			st_next.second = 1'b0;
			st_next.din_en = 1'b0;
			st_next.rel_pend = 1'b0;
		end else begin
			if (nact && st_reg.rel_pend) begin
				st_next.din_en = 1'b0; // RQ9
				st_next.rel_pend = 1'b0;
			end
			case (st_reg.fsm)
				ASRP_S_INSTR: begin
					if (act) begin
						st_next.sh = shin; // RQ2
						st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
						if (st_reg.bit_cnt == `ASRP_LAST_BIT) begin
							st_next.bit_cnt = 4'h0;
							st_next.second = 1'b0;
							st_next.addr = byte_in[4:0]; // RQ22
							st_next.wide = byte_in[`ASRP_INS_WIDE];
							if (byte_in[`ASRP_INS_DIRECT]) begin
								// Direct start: instruction carries gain and mux.
								wr_en = 1'b1; // RQ13
								wr_addr = `ASRP_ADDR_GAIN_MUX;
								wr_data = {1'b1, byte_in[6:0]};
							end else if (byte_in[`ASRP_INS_READ]) begin
								st_next.rd_sh = ord(rd(st_reg, byte_in[4:0]), lsb_first);
								st_next.fsm = ASRP_S_RDATA; // RQ7
							end else if (!byte_in[`ASRP_INS_WIDE]
									&& byte_in[4:0] == `ASRP_ADDR_RES_LO) begin
								rst_cmd = 1'b1; // RQ23
							end else begin
								st_next.fsm = ASRP_S_WDATA;
							end
						end
					end
				end
				ASRP_S_WDATA: begin
					if (act) begin
						st_next.sh = shin; // RQ24
						st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
						if (st_reg.bit_cnt == `ASRP_LAST_BIT) begin
							st_next.bit_cnt = 4'h0;
							if (st_reg.wide && !st_reg.second) begin
								st_next.wfirst = byte_in;
								st_next.second = 1'b1;
							end else begin
								wr_en = 1'b1; // RQ24
								wr_wide = st_reg.wide;
								st_next.fsm = ASRP_S_INSTR;
							end
						end
					end
				end
				ASRP_S_RDATA: begin
					if (nact) begin
						// Bits move only here, so they are stable at active edges.
						st_next.dout = st_reg.rd_sh[7]; // RQ8
						st_next.rd_sh = {st_reg.rd_sh[6:0], 1'b0};
						st_next.din_en = two_wire; // RQ9
					end
					if (act) begin
						st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
						if (st_reg.bit_cnt == 4'h0) begin
							// First bit already left; refresh the rest now.
							st_next.rd_sh = {rfr[6:0], 1'b0}; // RQ12
						end
						if (st_reg.bit_cnt == `ASRP_LAST_BIT) begin
							st_next.bit_cnt = 4'h0;
							if (st_reg.wide && !st_reg.second) begin
								st_next.second = 1'b1;
								st_next.rd_sh = ord(rd(st_reg, st_reg.addr ^ 5'h01), lsb_first); // RQ6
							end else begin
								st_next.second = 1'b0;
								st_next.rel_pend = st_reg.din_en;
								st_next.fsm = ASRP_S_INSTR; // RQ11
							end
						end
					end
				end
				default: begin
					st_next.fsm = ASRP_S_INSTR;
				end
			endcase
		end
		// Register commit: a wide write lands both bytes in the same cycle.
		if (wr_en) begin
			if (wr_wide) begin
				st_next = put(put(st_next, wr_addr, st_reg.wfirst), wr_addr ^ 5'h01,
					wr_data); // RQ5
			end else begin
				st_next = put(st_next, wr_addr, wr_data);
			end
		end
		// Reset command clears everything except the pin synchronisers, the clock edge history and the
		// data bit, which may only move on a non-active edge.
		if (rst_cmd) begin
			st_next = '0; // RQ17
			st_next.sel_p = st_reg.sel_p;
			st_next.ck_p = st_reg.ck_p;
			st_next.ck_d = st_reg.ck_d;
			st_next.di_p = st_reg.di_p;
			st_next.es_p = st_reg.es_p;
			st_next.dc_p = st_reg.dc_p;
			st_next.dc_d = st_reg.dc_d;
			st_next.dout = st_reg.dout; // RQ8
		end
	end

	// ********************************************************************
	// State register.
	// ********************************************************************
	// All registers clear to zero at reset, which also leaves the pins floating.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0; // RQ17
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	// ********************************************************************
	// Outputs.
	// ********************************************************************
	// The output pin is driven for as long as the port is selected.
	assign dout_oe_n_o    = ~sel; // RQ10
	assign dout_o         = st_reg.dout;
	assign din_o          = st_reg.dout;
	assign din_oe_n_o     = ~st_reg.din_en;
	assign conv_start_o   = st_reg.start;
	assign convert_busy_o = st_reg.busy;
	assign gain_o         = st_reg.r_gmux[6:4];
	assign clk_div_o      = st_reg.r_adc[1:0];
	assign dio_state_o    = st_reg.r_dio;
	assign dio_dir_o      = st_reg.r_dir;
	assign ref_ctrl_o     = st_reg.r_ref;

	// Mux decode of the gain/mux register low nibble.
	asrp_mux_decode u_mux (
		.mux_cfg_i      (st_reg.r_gmux[3:0]),
		.pos_line_o     (pos_line_o),
		.neg_line_o     (neg_line_o),
		.single_ended_o (single_ended_o)
	);

	// ********************************************************************
	// Assertions.
	// ********************************************************************
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i || !ce_i);

	sequence s_first_fall;
		st_reg.arm && dfall && st_reg.dcnt == 1'b0;
	endsequence

	sequence s_second_fall;
		st_reg.arm && dfall && st_reg.dcnt == 1'b1;
	endsequence

	a_cs_release_pin: assert property ($fell(sel) |-> dout_oe_n_o ##1 din_oe_n_o) // RQ10
		else $error("Output pin still driven after deselect.");
	a_cs_reset_fsm: assert property (!sel |=> st_reg.fsm == ASRP_S_INSTR && st_reg.bit_cnt == 4'h0) // RQ3
		else $error("Serial state not reset while deselected.");
	a_instr_bit_count: assert property (sel && act && st_reg.fsm == ASRP_S_INSTR
			&& st_reg.bit_cnt < `ASRP_LAST_BIT && !conv_done_i |=> st_reg.bit_cnt == $past(st_reg.bit_cnt) + 4'h1) // RQ2
		else $error("Instruction bit count did not advance.");
	a_conv_two_falls: assert property (s_first_fall ##1 (!dfall && !wr_en && !rst_cmd)[*1]
			|=> st_reg.arm) // RQ4
		else $error("Conversion armed state lost before second fall.");
	a_conv_start_cause: assert property (s_second_fall and !rst_cmd |=> conv_start_o && convert_busy_o) // RQ4
		else $error("Conversion did not start on second converter clock fall.");
	a_dout_change_edge: assert property (sel && $changed(dout_o) |-> $past(nact)) // RQ8
		else $error("Read data changed away from a non-active edge.");
	a_din_release_edge: assert property (sel && $rose(din_oe_n_o) |-> $past(nact)) // RQ9
		else $error("Shared data pin released away from a non-active edge.");
	a_wide_pair_addr: assert property (wr_en && wr_wide && !rst_cmd && wr_addr == `ASRP_ADDR_DIO_DIR
			|=> st_reg.r_dir == $past(st_reg.wfirst[3:0]) && st_reg.r_ref == $past(wr_data)) // RQ5
		else $error("Wide write did not land both bytes together.");
	a_reset_cmd_clear: assert property (rst_cmd |=> st_reg.r_adc == 8'h00 && st_reg.r_ser == 8'h00
			&& st_reg.fsm == ASRP_S_INSTR) // RQ23
		else $error("Reset command did not clear registers.");
	a_res_low_zero: assert property (conv_done_i && !rst_cmd |=> st_reg.res_lo[1] == 1'b0
			&& st_reg.res_lo[7:2] == $past(conv_result_i[5:0] ^ (st_reg.r_adc[`ASRP_BIN_BIT] ? 6'h00 : 6'h00))) // RQ18
		else $error("Result low byte layout wrong.");

endmodule // asrp_serial_port

// [tb/asrp_host_model.sv]
/*
 * Host model: a serial master that frames instructions and data on the port.
 * Assumes the bench resolves the shared data pin and calls frame() in turn.
 */
module asrp_host_model (
	// Clock and returned data.
	input  wire logic ref_clk_i,
	input  wire logic dout_i,
	// Serial pins driven by the host.
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      din_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle: deselected, with the clock parked low between frames.
	initial begin
		cs_n_o = 1'h1;
		sclk_o = 1'h0;
		din_o = 1'h0;
	end

	// Byte reversal for the least-significant-first order.
	function automatic logic [7:0] rv(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rv[i] = v[7 - i];
	endfunction

	// One frame, four reference cycles a half period; data is read two cycles after the rise.
	task automatic frame(input logic [7:0] ins, input int nd, input logic [15:0] wd,
			input logic lsb, input logic keep, output logic [15:0] rd);
		logic [23:0] sh;
		sh = lsb ? {rv(ins), rv(wd[15:8]), rv(wd[7:0])} : {ins, wd};
		rd = 16'h0000;
		cs_n_o <= 1'h0;
		repeat (4) @(posedge ref_clk_i);
		for (int i = 0; i < 8 + nd; i++) begin
			sclk_o <= 1'h0;
			din_o <= (i < 8 || !ins[6]) ? sh[23 - i] : ~din_o;
			repeat (4) @(posedge ref_clk_i);
			sclk_o <= 1'h1;
			repeat (2) @(posedge ref_clk_i);
			rd = {rd[14:0], dout_i};
			repeat (2) @(posedge ref_clk_i);
		end
		// The last falling edge lets the port release its read data.
		sclk_o <= 1'h0;
		din_o <= ~din_o;
		repeat (4) @(posedge ref_clk_i);
		cs_n_o <= !keep;
		repeat (4) @(posedge ref_clk_i);
		if (lsb)
			rd = {rv(rd[15:8]), rv(rd[7:0])};
	endtask
endmodule // asrp_host_model

// [tb/adc_serial_register_port_bench.sv]
/*
 * Self-checking bench for the serial register port.
 * Assumes the host model on the link and a simple conversion engine here.
 */
module adc_serial_register_port_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        ref_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        cclk = 1'h0;
	logic        done = 1'h0;
	logic        over_range_flag = 1'h0;
	logic [13:0] res = 14'h0000;
	logic [5:0]  amp = 6'h00;
	logic        cs_n, sclk, din_host, din_dev, din_oe_n, dout, dout_oe_n, start, busy, se;
	logic [2:0]  gain, pos, neg;
	logic [1:0]  cdiv;
	logic [3:0]  dio_st, dio_dir, start_falls;
	logic [7:0]  refc;
	logic [15:0] rd;
	logic [3:0]  cc_div = 4'h0;
	logic [3:0]  falls = 4'h0;
	logic        sclk_d = 1'h0;
	logic        started = 1'h0;
	logic        rise = 1'h1;
	int          n_mismatch = 0;
	int          compares = 0;

	asrp_host_model asrp_host_model_inst (.ref_clk_i(ref_clk), .dout_i(dout), .cs_n_o(cs_n),
		.sclk_o(sclk), .din_o(din_host));

	// The shared pin carries the port's data only while it enables its driver.
	asrp_serial_port asrp_serial_port_inst (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(1'h1),
		.cs_n_i(cs_n), .sclk_i(sclk ^ ~rise), .edge_rise_i(rise),
		.din_i(din_oe_n ? din_host : din_dev), .din_o(din_dev), .din_oe_n_o(din_oe_n),
		.dout_o(dout), .dout_oe_n_o(dout_oe_n), .converter_clock_i(cclk), .conv_done_i(done),
		.conv_result_i(res), .over_range_i(over_range_flag), .amp_valid_i(amp), .conv_start_o(start),
		.convert_busy_o(busy), .gain_o(gain), .pos_line_o(pos), .neg_line_o(neg),
		.single_ended_o(se), .clk_div_o(cdiv), .dio_state_o(dio_st), .dio_dir_o(dio_dir),
		.ref_ctrl_o(refc));

	// Reference clock, 50 ns period.
	always #25 ref_clk = ~ref_clk;

	// Converter clock of twelve cycles; falls since the last serial rise are counted.
	always @(posedge ref_clk) begin
		sclk_d <= sclk;
		cc_div <= (cc_div == 4'h5) ? 4'h0 : cc_div + 4'h1;
		if (cc_div == 4'h5)
			cclk <= ~cclk;
		if (sclk && !sclk_d)
			falls <= (cc_div == 4'h5 && cclk) ? 4'h1 : 4'h0;
		else if (cc_div == 4'h5 && cclk)
			falls <= falls + 4'h1;
		if (start) begin
			started <= 1'h1;
			start_falls <= falls;
		end
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic fr(input logic [7:0] ins, input int nd, input logic [15:0] wd,
			input logic lsb, input logic keep);
		asrp_host_model_inst.frame(ins, nd, wd, lsb, keep, rd);
	endtask

	// Conversion engine reports one result with a single-cycle pulse.
	task automatic convert(input logic [13:0] r, input logic o, input logic [5:0] a);
		res <= r;
		over_range_flag <= o;
		amp <= a;
		done <= 1'h1;
		@(posedge ref_clk);
		done <= 1'h0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic t_reset;
		fr(8'h60, 16, 16'h0000, 0, 1);
		chk("reset_result", rd, 16'h0000);
		chk("oe_selected", 16'(dout_oe_n), 16'h0000);
		fr(8'h40, 8, 16'h0000, 0, 0);
		chk("reset_low", rd, 16'h0000);
		chk("oe_idle", 16'(dout_oe_n), 16'h0001);
		$display("test reset done");
	endtask

	task automatic t_result;
		logic [13:0] r;
		r = 14'h2A5B;
		convert(r, 1'h1, 6'h00);
		fr(8'h61, 16, 16'h0000, 0, 0);
		chk("result_pair", rd, {r[13:6], r[5:0], 1'h0, 1'h1});
		convert(14'h1234, 1'h0, 6'h24);
		fr(8'h62, 16, 16'h0000, 0, 0);
		chk("amp_valid", rd, 16'h2400);
		fr(8'h40, 8, 16'h0000, 0, 0);
		chk("over_flag", 16'(rd[0]), 16'h0001);
		$display("test result done");
	endtask

	task automatic t_wide;
		fr(8'h26, 16, 16'h0503, 0, 0);
		chk("wide_pair", {refc, 4'h0, dio_dir}, 16'h0305);
		fr(8'h07, 4, 16'hFF00, 0, 0);
		chk("aborted", 16'(refc), 16'h0003);
		fr(8'h07, 8, 16'hC300, 0, 0);
		chk("after_abort", 16'(refc), 16'h00C3);
		$display("test wide done");
	endtask

	task automatic t_order;
		fr(8'h18, 8, 16'h8100, 0, 1);
		fr(8'h46, 8, 16'h0000, 1, 1);
		chk("lsb_read", 16'(rd[7:0]), 16'h0005);
		fr(8'h18, 8, 16'h0000, 1, 0);
		fr(8'h46, 8, 16'h0000, 0, 0);
		chk("msb_read", 16'(rd[7:0]), 16'h0005);
		fr(8'h18, 8, 16'h4200, 0, 1);
		fr(8'h46, 8, 16'h0000, 0, 1);
		chk("two_wire_read", 16'(rd[7:0]), 16'h0005);
		chk("two_wire_release", 16'(din_oe_n), 16'h0001);
		fr(8'h18, 8, 16'h0000, 0, 0);
		rise <= 1'h0;
		repeat (4) @(posedge ref_clk);
		fr(8'h46, 8, 16'h0000, 0, 0);
		chk("fall_read", 16'(rd[7:0]), 16'h0005);
		rise <= 1'h1;
		repeat (4) @(posedge ref_clk);
		$display("test order done");
	endtask

	task automatic t_mux;
		logic [3:0] cd;
		logic [2:0] base;
		for (int c = 0; c < 16; c++) begin
			cd = 4'(c);
			fr(8'h04, 8, {4'h5, cd, 8'h00}, 0, 0);
			base = {cd[1:0], 1'h0};
			chk("gain", 16'(gain), 16'h0005);
			chk("mode", 16'(se), 16'(cd[3]));
			chk("pos", 16'(pos), cd[3] ? 16'(cd[2:0]) : 16'(base + cd[2]));
			if (!cd[3])
				chk("neg", 16'(neg), 16'(base + !cd[2]));
		end
		$display("test mux done");
	endtask

	// Start by gain/mux write, by digital I/O write and by direct instruction.
	task automatic t_conv;
		int i;
		for (int k = 0; k < 3; k++) begin
			started <= 1'h0;
			fr((k == 0) ? 8'h04 : (k == 1) ? 8'h05 : 8'h8B, (k == 2) ? 0 : 8, 16'h8000, 0, 0);
			for (i = 0; i < 400 && !started; i++)
				@(posedge ref_clk);
			if (!started) begin
				n_mismatch++;
				report_and_stop();
			end
			chk("start_falls", 16'(start_falls), 16'h0002);
			chk("busy_set", 16'(busy), 16'h0001);
			convert(14'h0000, 1'h0, 6'h00);
			chk("busy_clear", 16'(busy), 16'h0000);
		end
		chk("direct_mux", {7'h00, se, 5'h00, pos}, 16'h0103);
		$display("test conv done");
	endtask

	task automatic t_rstcmd;
		fr(8'h25, 16, 16'h0906, 0, 0);
		chk("dio_pair", {12'h000, dio_st}, 16'h0009);
		fr(8'h03, 8, 16'h2300, 0, 0);
		chk("clk_div", 16'(cdiv), 16'h0003);
		convert(14'h0000, 1'h0, 6'h00);
		fr(8'h41, 8, 16'h0000, 0, 0);
		chk("binary_hi", 16'(rd[7:0]), 16'h0080);
		fr(8'h00, 0, 16'h0000, 0, 0);
		chk("after_cmd", {refc, dio_dir, 1'h0, gain}, 16'h0000);
		chk("after_cmd_more", {dio_st, 10'h000, cdiv}, 16'h0000);
		$display("test rstcmd done");
	endtask

	// Reset for sixteen cycles, then the scenarios in turn.
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge ref_clk);
		t_reset();
		t_result();
		t_wide();
		t_order();
		t_mux();
		t_conv();
		t_rstcmd();
		report_and_stop();
	end
endmodule // adc_serial_register_port_bench
